// File: core/scfg_pkg.sv
package scfg_pkg;

   // ----------------------------------------------------------------
   // Configuration indices and values after reset.
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_DEC_LOWER = 8'h08;  // Lower decode address.
   localparam logic [7:0] IDX_DEC_UPPER = 8'h09;  // Upper decode address and mode.
   localparam logic [7:0] IDX_ECP_IR    = 8'h0a;  // ECP threshold and IR routing.
   localparam logic [7:0] IDX_RATE      = 8'h0b;  // Drive rate table selection.
   localparam logic [7:0] IDX_UART      = 8'h0c;  // UART mode control.
   localparam logic [7:0] RST_DEC_LOWER = 8'h00;
   localparam logic [7:0] RST_DEC_UPPER = 8'h00;
   localparam logic [7:0] RST_ECP_IR    = 8'h00;
   localparam logic [7:0] RST_RATE      = 8'h00;
   localparam logic [7:0] RST_UART      = 8'h02;
   localparam logic [7:0] RST_INDEX     = 8'h00;  // Index register after reset.

   // ----------------------------------------------------------------
   // Writable bit masks; cleared bits are reserved and read as zero.
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_DEC_LOWER = 8'hf0;
   localparam logic [7:0] MASK_DEC_UPPER = 8'hcf;
   localparam logic [7:0] MASK_ECP_IR    = 8'hcf;
   localparam logic [7:0] MASK_RATE      = 8'hff;
   localparam logic [7:0] MASK_UART      = 8'hff;

   // ----------------------------------------------------------------
   // Encodings of the mode fields.
   // ----------------------------------------------------------------
   localparam logic [1:0] DEC_MODE_OFF     = 2'h0;  // Decoder disabled.
   localparam logic [1:0] DEC_MODE_BYTE    = 2'h1;  // Single byte, low nibble zero.
   localparam logic [1:0] DEC_MODE_BLOCK8  = 2'h2;  // Eight bytes, bit 3 zero.
   localparam logic [1:0] DEC_MODE_BLOCK16 = 2'h3;  // Sixteen bytes.
   localparam logic [3:0] DEC_TOP_ZERO     = 4'h0;  // Address bits 15:12.
   localparam logic [3:0] DEC_LOW_ZERO     = 4'h0;  // Address bits 3:0 in byte mode.
   localparam logic [1:0] IR_ROUTE_PRIMARY   = 2'h0;
   localparam logic [1:0] IR_ROUTE_SECONDARY = 2'h1;
   localparam logic [1:0] IR_ROUTE_RESERVED  = 2'h2;
   localparam logic [1:0] IR_ROUTE_OFF       = 2'h3;
   localparam logic [2:0] UART2_MODE_STANDARD = 3'h0;
   localparam logic [2:0] UART2_MODE_PULSE_IR = 3'h1;
   localparam logic [2:0] UART2_MODE_ASK_IR   = 3'h2;

   // ----------------------------------------------------------------
   // Carriers; packed so that bit 7 of each register comes first.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       cfgMode;  // Configuration state is active.
      logic       idxWr;    // Write to the index port.
      logic       dataWr;   // Write to the data port.
      logic       dataRd;   // Read from the data port.
      logic [7:0] wdata;    // Write data.
   } scfg_host_req_t;

   typedef struct packed {
      logic       rdValid;  // Read data is valid this cycle.
      logic [7:0] rdata;    // Read data.
   } scfg_host_rsp_t;

   typedef struct packed {
      logic [1:0] mode;     // Decoder mode.
      logic [1:0] rsvd;     // Always zero.
      logic [3:0] addrHi;   // Decode address bits 11:8.
   } scfg_dec_upper_t;

   typedef struct packed {
      logic [1:0] irRoute;  // IR output routing.
      logic [1:0] rsvd;     // Always zero.
      logic [3:0] ecpThreshold;
   } scfg_ecp_ir_t;

   typedef struct packed {
      logic       uart2HighSpeed;
      logic       uart1HighSpeed;
      logic [2:0] uart2Mode;
      logic       uart2HalfDuplex;
      logic       uart2TxInvert;
      logic       uart2RxInvert;
   } scfg_uart_mode_t;

endpackage

// File: core/scfg_addr_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// General address decoder match, purely combinational.
// ------------------------------------------------------------------
module scfg_addr_decode #(
   parameter int ADDR_W = 16
) (
   // Host address.
   input  wire logic [ADDR_W-1:0] hostAddr,
   input  wire logic              hostAddrValid,
   // Programmed decode.
   input  wire logic [1:0]        decMode,
   input  wire logic [7:0]        decAddr,
   // Result.
   output logic                   hit
);

   // The bit split below assumes a sixteen-bit I/O address.
   if (ADDR_W != 16) begin : g_check
      $error("scfg_addr_decode serves a 16-bit address only");
   end

   logic upperOk;  // Bits 15:12 zero and 11:4 equal the programmed value.
   logic lowOk;    // Low nibble qualifies for the selected block size.

   // Match the upper bits and pick the low-nibble test by mode.
   always_comb begin
      upperOk = (hostAddr[15:12] == scfg_pkg::DEC_TOP_ZERO) &&
                (hostAddr[11:4] == decAddr);
      unique case (decMode)
         scfg_pkg::DEC_MODE_OFF:    lowOk = 1'b0;
         scfg_pkg::DEC_MODE_BYTE:   lowOk = (hostAddr[3:0] == scfg_pkg::DEC_LOW_ZERO);
         scfg_pkg::DEC_MODE_BLOCK8: lowOk = ~hostAddr[3];
         scfg_pkg::DEC_MODE_BLOCK16: lowOk = 1'b1;  // Sixteen-byte block.
      endcase
      hit = hostAddrValid && upperOk && lowOk;
   end

endmodule

// File: core/scfg_regs.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Configuration registers for the address decoder, ECP threshold,
// IR routing, drive rate tables and UART modes.
// ------------------------------------------------------------------
module scfg_regs (
   // Clock and reset.
   input  wire logic                   sys_clk,
   input  wire logic                   rstn,
   // Configuration port accesses from the index logic.
   input  wire scfg_pkg::scfg_host_req_t cfgReq,
   output scfg_pkg::scfg_host_rsp_t    cfgRsp,
   // Host address for the general decoder.
   input  wire logic [15:0]            hostAddr,
   input  wire logic                   hostAddrValid,
   output logic                        generalDecodeSelectN,
   // Parallel port threshold.
   output logic [3:0]                  ecpThreshold,
   // IR routing between the active device and the pins.
   input  wire logic                   irTxData,
   output logic                        irRxData,
   input  wire logic                   irPrimaryRx,
   input  wire logic                   irSecondaryRx,
   output logic                        irPrimaryTx,
   output logic                        irPrimaryTxOe,
   output logic                        irSecondaryTx,
   output logic                        irSecondaryTxOe,
   output logic [1:0]                  irRoute,
   // Floppy drive rate table selectors, two bits per drive.
   output logic [7:0]                  rateTableSel,
   // UART operating modes.
   output logic                        uart2RxInvert,
   output logic                        uart2TxInvert,
   output logic                        uart2HalfDuplex,
   output logic [2:0]                  uart2Mode,
   output logic                        uart1HighSpeed,
   output logic                        uart2HighSpeed
);

   // ---------------------------------------------------------------
   // State of the block.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                 cfgIndex;    // Loaded configuration index.
      logic [7:0]                 decLower;    // Lower decode address register.
      scfg_pkg::scfg_dec_upper_t  decUpper;    // Upper decode and mode register.
      scfg_pkg::scfg_ecp_ir_t     ecpIr;       // Threshold and routing register.
      logic [7:0]                 rateSel;     // Drive rate table register.
      scfg_pkg::scfg_uart_mode_t  uartMode;    // UART mode register.
      scfg_pkg::scfg_host_rsp_t   rsp;         // Registered read answer.
      logic                       decSelN;     // Registered decode select.
      logic [2:0]                 rxSyncPri;   // Primary receive synchroniser.
      logic [2:0]                 rxSyncSec;   // Secondary receive synchroniser.
      logic                       rxStablePri; // Accepted primary receive level.
      logic                       rxStableSec; // Accepted secondary receive level.
      logic                       rxOut;       // Receive level to the device.
      logic                       priTx;       // Primary transmit pin value.
      logic                       priTxOe;     // Primary transmit pin enable.
      logic                       secTx;       // Secondary transmit pin value.
      logic                       secTxOe;     // Secondary transmit pin enable.
   } scfg_state_t;

   scfg_state_t st_r;   // Current state.
   scfg_state_t st_nxt; // Next state.
   logic        decHit; // Combinational decoder match.

   // ---------------------------------------------------------------
   // Address decoder.
   // ---------------------------------------------------------------

   // The match is registered below, so the select lags the address
   // by one clock; this keeps the output glitch free.
   scfg_addr_decode #(
      .ADDR_W        (16)
   ) u_decode (
      .hostAddr      (hostAddr),
      .hostAddrValid (hostAddrValid),
      .decMode       (st_r.decUpper.mode),
      .decAddr       ({st_r.decUpper.addrHi, st_r.decLower[7:4]}),
      .hit           (decHit)
   );

   // ---------------------------------------------------------------
   // Next-state logic.
   // ---------------------------------------------------------------

   // Register accesses, pin synchronisers and IR routing.
   always_comb begin
      st_nxt = st_r;

      // Index and data port accesses only count in configuration state.
      // An index write in the same cycle as a data access wins, and the
      // data access is dropped, since its target would be ambiguous.
      st_nxt.rsp.rdValid = 1'b0;
      if (cfgReq.cfgMode) begin
         if (cfgReq.idxWr) begin
            st_nxt.cfgIndex = cfgReq.wdata;
         end else if (cfgReq.dataWr) begin
            // Writes are masked so reserved bits stay at zero.
            unique case (st_r.cfgIndex)
               scfg_pkg::IDX_DEC_LOWER: begin
                  st_nxt.decLower = cfgReq.wdata & scfg_pkg::MASK_DEC_LOWER;
               end
               scfg_pkg::IDX_DEC_UPPER: begin
                  st_nxt.decUpper = cfgReq.wdata & scfg_pkg::MASK_DEC_UPPER;
               end
               scfg_pkg::IDX_ECP_IR: begin
                  st_nxt.ecpIr = cfgReq.wdata & scfg_pkg::MASK_ECP_IR;
               end
               scfg_pkg::IDX_RATE: begin
                  st_nxt.rateSel = cfgReq.wdata & scfg_pkg::MASK_RATE;
               end
               scfg_pkg::IDX_UART: begin
                  st_nxt.uartMode = cfgReq.wdata & scfg_pkg::MASK_UART;
               end
               default: begin
                  // Other indices belong to neighbouring registers.
               end
            endcase
         end else if (cfgReq.dataRd) begin
            // Every read gets an answer; unknown indices read as zero.
            st_nxt.rsp.rdValid = 1'b1;
            unique case (st_r.cfgIndex)
               scfg_pkg::IDX_DEC_LOWER: st_nxt.rsp.rdata = st_r.decLower;
               scfg_pkg::IDX_DEC_UPPER: st_nxt.rsp.rdata = st_r.decUpper;
               scfg_pkg::IDX_ECP_IR:    st_nxt.rsp.rdata = st_r.ecpIr;
               scfg_pkg::IDX_RATE:      st_nxt.rsp.rdata = st_r.rateSel;
               scfg_pkg::IDX_UART:      st_nxt.rsp.rdata = st_r.uartMode;
               default:                 st_nxt.rsp.rdata = 8'h00;
            endcase
         end
      end

      // Decode select is active low and follows the registered match.
      st_nxt.decSelN = ~decHit;

      // Receive pins come from outside the clock domain. The first
      // stage feeds only the second; a level is accepted once the
      // second and third stages agree, which rejects a single-cycle
      // metastable flicker at the cost of one more cycle of delay.
      st_nxt.rxSyncPri = {st_r.rxSyncPri[1:0], irPrimaryRx};
      st_nxt.rxSyncSec = {st_r.rxSyncSec[1:0], irSecondaryRx};
      if (st_r.rxSyncPri[2] == st_r.rxSyncPri[1]) begin
         st_nxt.rxStablePri = st_r.rxSyncPri[2];
      end
      if (st_r.rxSyncSec[2] == st_r.rxSyncSec[1]) begin
         st_nxt.rxStableSec = st_r.rxSyncSec[2];
      end

      // Route the active IR device to one pin pair. The reserved code
      // is treated like the off code so no pin is driven by surprise.
      unique case (st_r.ecpIr.irRoute)
         scfg_pkg::IR_ROUTE_PRIMARY: begin
            st_nxt.priTx   = irTxData;
            st_nxt.priTxOe = 1'b1;
            st_nxt.secTx   = 1'b0;
            st_nxt.secTxOe = 1'b0;
            st_nxt.rxOut   = st_r.rxStablePri;
         end
         scfg_pkg::IR_ROUTE_SECONDARY: begin
            st_nxt.priTx   = 1'b0;
            st_nxt.priTxOe = 1'b0;
            st_nxt.secTx   = irTxData;
            st_nxt.secTxOe = 1'b1;
            st_nxt.rxOut   = st_r.rxStableSec;
         end
         scfg_pkg::IR_ROUTE_RESERVED: begin
            st_nxt.priTx   = 1'b0;
            st_nxt.priTxOe = 1'b0;
            st_nxt.secTx   = 1'b0;
            st_nxt.secTxOe = 1'b0;
            st_nxt.rxOut   = 1'b0;
         end
         scfg_pkg::IR_ROUTE_OFF: begin
            // Both transmit outputs released to high impedance.
            st_nxt.priTx   = 1'b0;
            st_nxt.priTxOe = 1'b0;
            st_nxt.secTx   = 1'b0;
            st_nxt.secTxOe = 1'b0;
            st_nxt.rxOut   = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register.
   // ---------------------------------------------------------------

   // Reset loads only constants; power-on and hardware reset both
   // arrive on rstn and return every register to its default.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r.cfgIndex    <= scfg_pkg::RST_INDEX;
         st_r.decLower    <= scfg_pkg::RST_DEC_LOWER;
         st_r.decUpper    <= scfg_pkg::RST_DEC_UPPER;
         st_r.ecpIr       <= scfg_pkg::RST_ECP_IR;
         st_r.rateSel     <= scfg_pkg::RST_RATE;
         st_r.uartMode    <= scfg_pkg::RST_UART;
         st_r.rsp         <= '0;
         st_r.decSelN     <= 1'b1;
         st_r.rxSyncPri   <= 3'h0;
         st_r.rxSyncSec   <= 3'h0;
         st_r.rxStablePri <= 1'b0;
         st_r.rxStableSec <= 1'b0;
         st_r.rxOut       <= 1'b0;
         st_r.priTx       <= 1'b0;
         st_r.priTxOe     <= 1'b0;
         st_r.secTx       <= 1'b0;
         st_r.secTxOe     <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, each straight from the state register.
   // ---------------------------------------------------------------
   assign cfgRsp               = st_r.rsp;
   assign generalDecodeSelectN = st_r.decSelN;
   assign ecpThreshold         = st_r.ecpIr.ecpThreshold;
   assign irRoute              = st_r.ecpIr.irRoute;
   assign irRxData             = st_r.rxOut;
   assign irPrimaryTx          = st_r.priTx;
   assign irPrimaryTxOe        = st_r.priTxOe;
   assign irSecondaryTx        = st_r.secTx;
   assign irSecondaryTxOe      = st_r.secTxOe;
   assign rateTableSel         = st_r.rateSel;
   // The UART only reads these levels; polarity and mode act there.
   assign uart2RxInvert        = st_r.uartMode.uart2RxInvert;
   assign uart2TxInvert        = st_r.uartMode.uart2TxInvert;
   assign uart2HalfDuplex      = st_r.uartMode.uart2HalfDuplex;
   assign uart2Mode            = st_r.uartMode.uart2Mode;
   assign uart1HighSpeed       = st_r.uartMode.uart1HighSpeed;
   assign uart2HighSpeed       = st_r.uartMode.uart2HighSpeed;

endmodule

// File: dv/scfg_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Host bus controller model driving the configuration port.
// ------------------------------------------------------------------
module scfg_host_model (
   // Clock.
   input  wire logic                     sys_clk,
   // Configuration port towards the block.
   output scfg_pkg::scfg_host_req_t      cfgReq,
   input  wire scfg_pkg::scfg_host_rsp_t cfgRsp
);
   logic       rspValid;  // Answer flag seen one cycle after the request.
   logic [7:0] rspData;   // Read data captured with that flag.

   // The port starts idle: no strobes and outside the configuration state.
   initial cfgReq = '0;

   // One access: raised after a falling edge, taken at the next rising edge, answer
   // captured at the falling edge after it, then strobes dropped. The data lines go
   // to the inverse of the last value, so stale data can never pass for a match.
   task automatic access(input logic cfg, input logic [2:0] kind, input logic [7:0] data);
      @(negedge sys_clk);
      cfgReq <= {cfg, kind, data};
      @(negedge sys_clk);
      rspValid = cfgRsp.rdValid;
      rspData  = cfgRsp.rdata;
      cfgReq <= {cfg, 3'b000, ~data};
   endtask
endmodule

// File: dv/scfg_regs_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port-level checks for the configuration register block.
// ------------------------------------------------------------------
module scfg_regs_properties (
   // Clock and reset.
   input wire logic                     sys_clk,
   input wire logic                     rstn,
   // Configuration port.
   input wire scfg_pkg::scfg_host_req_t cfgReq,
   input wire scfg_pkg::scfg_host_rsp_t cfgRsp,
   // Decoder and IR pins.
   input wire logic [15:0]              hostAddr,
   input wire logic                     hostAddrValid,
   input wire logic                     generalDecodeSelectN,
   input wire logic                     irTxData,
   input wire logic                     irRxData,
   input wire logic                     irPrimaryRx,
   input wire logic                     irPrimaryTx,
   input wire logic                     irPrimaryTxOe,
   input wire logic                     irSecondaryTx,
   input wire logic                     irSecondaryTxOe,
   input wire logic [1:0]               irRoute,
   // Register fields.
   input wire logic [3:0]               ecpThreshold,
   input wire logic [7:0]               rateTableSel,
   input wire logic [2:0]               uart2Mode
);
   logic rdTaken;  // A data read the block must answer.
   logic wrTaken;  // A data write the block must apply.

   // Index writes win over data accesses, and a write wins over a read.
   assign rdTaken = cfgReq.cfgMode & cfgReq.dataRd & ~cfgReq.dataWr & ~cfgReq.idxWr;
   assign wrTaken = cfgReq.cfgMode & cfgReq.dataWr & ~cfgReq.idxWr;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   chk_read_answer: assert property (rdTaken |=> cfgRsp.rdValid)
      else $error("Read answer missing one cycle after a read");
   chk_no_stray_answer: assert property (!rdTaken |=> !cfgRsp.rdValid)
      else $error("Read answer without an accepted read");
   chk_rdata_hold: assert property (!rdTaken |=> $stable(cfgRsp.rdata))
      else $error("Read data changed without a read");
   chk_fields_hold: assert property (!wrTaken |=>
      $stable({ecpThreshold, irRoute, rateTableSel, uart2Mode}))
      else $error("Register field changed without a write");
   chk_decode_top: assert property ((hostAddr[15:12] != 4'h0 || !hostAddrValid)[*2]
      |-> generalDecodeSelectN)
      else $error("Decode select low for an excluded address");
   chk_route_primary: assert property (irRoute == 2'h0 |=> irPrimaryTxOe
      && !irSecondaryTxOe && irPrimaryTx == $past(irTxData))
      else $error("Primary IR transmit not routed");
   chk_route_second: assert property (irRoute == 2'h1 |=> irSecondaryTxOe
      && !irPrimaryTxOe && irSecondaryTx == $past(irTxData))
      else $error("Secondary IR transmit not routed");
   chk_route_off: assert property (irRoute[1] |=> !irPrimaryTxOe && !irSecondaryTxOe
      && !irPrimaryTx && !irSecondaryTx && !irRxData)
      else $error("IR outputs active while routing is off");
   chk_rx_primary: assert property ((irRoute == 2'h0 && $stable(irPrimaryRx))[*6]
      |-> irRxData == irPrimaryRx)
      else $error("Primary IR receive not passed to the device");
endmodule

bind scfg_regs scfg_regs_properties u_chk (.sys_clk(sys_clk), .rstn(rstn), .cfgReq(cfgReq),
   .cfgRsp(cfgRsp), .hostAddr(hostAddr), .hostAddrValid(hostAddrValid),
   .generalDecodeSelectN(generalDecodeSelectN), .irTxData(irTxData), .irRxData(irRxData),
   .irPrimaryRx(irPrimaryRx), .irPrimaryTx(irPrimaryTx), .irPrimaryTxOe(irPrimaryTxOe),
   .irSecondaryTx(irSecondaryTx), .irSecondaryTxOe(irSecondaryTxOe), .irRoute(irRoute),
   .ecpThreshold(ecpThreshold), .rateTableSel(rateTableSel), .uart2Mode(uart2Mode));

// File: dv/scfg_regs_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Self-checking bench for the configuration register block.
// ------------------------------------------------------------------
module scfg_regs_tb;
   logic sys_clk = 1'b0, rstn = 1'b0, hostAddrValid = 1'b0, irTxData = 1'b0;
   logic irPrimaryRx = 1'b0, irSecondaryRx = 1'b0, hit;
   logic [15:0] hostAddr = 16'h0000;
   scfg_pkg::scfg_host_req_t cfgReq;
   scfg_pkg::scfg_host_rsp_t cfgRsp;
   logic generalDecodeSelectN, irRxData, irPrimaryTx, irPrimaryTxOe, irSecondaryTx;
   logic irSecondaryTxOe, uart2RxInvert, uart2TxInvert, uart2HalfDuplex, uart1HighSpeed;
   logic uart2HighSpeed;
   logic [1:0] irRoute;
   logic [2:0] uart2Mode;
   logic [3:0] ecpThreshold;
   logic [7:0] rateTableSel;
   int failures = 0, samples_checked = 0;
   // Rows: index, written value, value read back (reserved bits read zero).
   logic [23:0] rows [6] = '{24'h09ffcf, 24'h0affcf, 24'h0ba5a5, 24'h0cffff, 24'h08fff0,
                             24'h0d5a00};
   logic [7:0]  uartVals [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};
   logic [15:0] addrs [7] = '{16'h0230, 16'h0237, 16'h0238, 16'h023f, 16'h1230, 16'h0330,
                              16'h0130};

   always #4 sys_clk = ~sys_clk;

   scfg_host_model host (.sys_clk(sys_clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));
   scfg_regs dut (.sys_clk(sys_clk), .rstn(rstn), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
      .hostAddr(hostAddr), .hostAddrValid(hostAddrValid),
      .generalDecodeSelectN(generalDecodeSelectN), .ecpThreshold(ecpThreshold),
      .irTxData(irTxData), .irRxData(irRxData), .irPrimaryRx(irPrimaryRx),
      .irSecondaryRx(irSecondaryRx), .irPrimaryTx(irPrimaryTx), .irPrimaryTxOe(irPrimaryTxOe),
      .irSecondaryTx(irSecondaryTx), .irSecondaryTxOe(irSecondaryTxOe), .irRoute(irRoute),
      .rateTableSel(rateTableSel), .uart2RxInvert(uart2RxInvert),
      .uart2TxInvert(uart2TxInvert), .uart2HalfDuplex(uart2HalfDuplex),
      .uart2Mode(uart2Mode), .uart1HighSpeed(uart1HighSpeed),
      .uart2HighSpeed(uart2HighSpeed));

   // Value and flag comparisons; every call is counted.
   task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask
   task automatic chk1(string name, logic exp, logic got);
      chk8(name, {7'h00, exp}, {7'h00, got});
   endtask

   // Register access through the index and data ports.
   task automatic regWr(logic [7:0] idx, logic [7:0] data);
      host.access(1'b1, 3'b100, idx);
      host.access(1'b1, 3'b010, data);
   endtask
   task automatic regRd(logic [7:0] idx, string name, logic [7:0] exp);
      host.access(1'b1, 3'b100, idx);
      host.access(1'b1, 3'b001, 8'h00);
      chk1("read answer", 1'b1, host.rspValid);
      chk8(name, exp, host.rspData);
   endtask
   task automatic chkDefaults();
      regRd(8'h09, "decoder upper reset", 8'h00);
      regRd(8'h0a, "ecp ir reset", 8'h00);
      regRd(8'h0b, "rate reset", 8'h00);
      regRd(8'h0c, "uart mode reset", 8'h02);
      chk1("tx invert reset", 1'b1, uart2TxInvert);
   endtask

   // Closing report, shared by the main sequence and the watchdog.
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // The run needs a few hundred cycles; a hang is cut off well beyond that.
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) rstn = 1'b1;
      chkDefaults();
      foreach (rows[i]) begin
         regWr(rows[i][23:16], rows[i][15:8]);
         regRd(rows[i][23:16], "row readback", rows[i][7:0]);
      end
      chk8("ecp threshold", 8'h0f, {4'h0, ecpThreshold});
      chk8("rate select", 8'ha5, rateTableSel);
      // Each mode bit alone except bit 5, the two defined IR codes among them.
      foreach (uartVals[i]) begin
         regWr(8'h0c, uartVals[i]);
         chk8("uart fields", uartVals[i], {uart2HighSpeed, uart1HighSpeed, uart2Mode,
            uart2HalfDuplex, uart2TxInvert, uart2RxInvert});
      end
      // Every routing code, with pins set so that the wrong path would show.
      for (int r = 0; r < 4; r++) begin
         regWr(8'h0a, {r[1:0], 6'h00});
         irTxData = 1'b1;
         irPrimaryRx = ~r[0];
         irSecondaryRx = r[0];
         repeat (8) @(negedge sys_clk);
         chk8("ir route", {6'h00, r[1:0]}, {6'h00, irRoute});
         chk8("ir pins", {3'h0, r == 0, r == 0, r == 1, r == 1, !r[1]}, {3'h0, irPrimaryTxOe,
            irPrimaryTx, irSecondaryTxOe, irSecondaryTx, irRxData});
         irTxData = 1'b0;
      end
      // Every decoder mode against a set of boundary addresses around 0x230.
      regWr(8'h08, 8'h30);
      hostAddrValid = 1'b1;
      for (int m = 0; m < 4; m++) begin
         regWr(8'h09, {m[1:0], 6'h02});
         foreach (addrs[j]) begin
            hostAddr = addrs[j];
            repeat (2) @(negedge sys_clk);
            hit = addrs[j][15:4] == 12'h023 && (m == 3 || (m == 2 && !addrs[j][3])
                  || (m == 1 && addrs[j][3:0] == 4'h0));
            chk1("decode select", !hit, generalDecodeSelectN);
         end
      end
      // Accesses outside the configuration state are refused.
      host.access(1'b0, 3'b100, 8'h0c);
      host.access(1'b0, 3'b010, 8'h55);
      host.access(1'b0, 3'b001, 8'h00);
      chk1("answer outside config", 1'b0, host.rspValid);
      regRd(8'h0c, "uart after refused write", 8'h80);
      // A second reset in mid-run restores the defaults of indices 0x09 to 0x0c.
      @(negedge sys_clk) rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      chkDefaults();
      print_verdict();
   end
endmodule
